//--- shared/apd_pkg.sv
// Purpose: constants for the phase delay and reset control block
// Assumes: 8-bit registers reached by a plain write/read port
// Notes: oversampling code 0..7 means ratio 32..4096
package apd_pkg;
  localparam logic [4:0] PHASE_HI_ADDR = 5'h07;
  localparam logic [4:0] PHASE_LO_ADDR = 5'h08;
  localparam logic [4:0] CONFIG_ADDR = 5'h09;
  localparam logic [4:0] TRIM_ADDR = 5'h1a;
  localparam logic [7:0] TRIM_RST = 8'h42;
  localparam logic [11:0] PHASE_RST = 12'h000;
  localparam logic [2:0] OSR_RST = 3'h3;
  localparam logic EXT_CLK_RST = 1'b0;
  localparam int CFG_OSR_LSB = 0;
  localparam int CFG_EXT_CLK_BIT = 3;
  localparam logic [3:0] CMP_RESET_CODE = 4'h3;
  localparam int PHASE_W = 12;
  localparam int OSR_MIN = 32;
  localparam int SYS_PERIOD_NS = 50;
  localparam int POR_TIME_US = 50;
  localparam int POR_CYC = (POR_TIME_US * 1000) / SYS_PERIOD_NS;
endpackage

//--- rtl/apd_ctrl.sv
// Purpose: phase delay, hard reset and power-on control of a two-channel converter
// Assumes: register port is synchronous to sys_clk_i; modulator bits are on the
//   digital master clock
// Notes: all state held in one struct per clock domain
// Operation
// - trim register at 0x1A, resets 0x42
// - watch both rails, start 50 us later
// - after power-on, ready pulses with defaults
// - reset pin low gives zero output
// - reset clears modulators, comparators show 0011
// - reset clears filters, buffers, returns all registers to defaults
// - reset ignores writes, ready and modulator bit outputs go high impedance
// - sample together, delay one channel's averaging
// - 12-bit signed phase, upper nibble reads zero
// - positive phase makes channel 0 lag
// - delay is code times master clock period
// - ready timing offset by phase delay
// - phase range minus half to half-minus-one ratio
// - sign bit moves with oversampling ratio
// - any phase write restarts both converters
// - external clock select bypasses crystal
// - ready pulses low on new data
`timescale 1ns/1ns
module apd_ctrl import apd_pkg::*; #(
  parameter int POR_CYCLES = POR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic reset_pin_n_i,
  input wire logic analog_supply_ok_i,
  input wire logic digital_supply_ok_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] reference_tempco_trim_o,
  output logic external_clock_select_o,
  input wire logic digital_master_clock_i,
  input wire logic digital_master_clock_rst_i,
  input wire logic [1:0] modulator_bit_i,
  input wire logic [3:0] cmp0_code_i,
  input wire logic [3:0] cmp1_code_i,
  output logic [3:0] cmp0_code_o,
  output logic [3:0] cmp1_code_o,
  output logic bias_enable_o,
  output logic [12:0] ch0_data_o,
  output logic [12:0] ch1_data_o,
  output logic sample_ready_n_o,
  output logic sample_ready_n_oe_o,
  output logic [1:0] modulator_bit_out_o,
  output logic modulator_bit_out_oe_o
);
  localparam int PCW = $clog2(POR_CYCLES + 1);
  localparam logic [PCW-1:0] POR_LAST = PCW'(POR_CYCLES - 1);

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] avdd_s;
    logic [1:0] dvdd_s;
    logic [PCW-1:0] por_cnt;
    logic por_done;
    logic hold;
    logic [11:0] phase;
    logic [2:0] oversampling_ratio;
    logic ext_clk;
    logic [7:0] trim;
    logic restart_t;
    logic [7:0] rdata;
  } apd_sys_t;

  typedef struct packed {
    logic [1:0] hold_s;
    logic [2:0] rst_t_s;
    logic [11:0] ph;
    logic [2:0] oversampling_ratio;
    logic [1:0][11:0] dly;
    logic [1:0][11:0] win;
    logic [1:0][12:0] acc;
    logic [1:0][12:0] dat;
    logic rdy_n;
    logic oe_n;
    logic [1:0] mbit;
    logic [3:0] cmp0;
    logic [3:0] cmp1;
    logic bias;
    logic ld;
  } apd_lnk_t;

  apd_sys_t s_q, s_d;
  apd_lnk_t l_q, l_d;
  logic restart_ev;
  logic [11:0] len_m1;
  logic signed [11:0] ph_eff;
  logic [11:0] lag0, lag1;

  // ratio is 32 shifted by the code
  function automatic logic [12:0] osr_len(input logic [2:0] code);
    osr_len = 13'(OSR_MIN) << code;
  endfunction

  // sign bit sits at code+4, so shift up and back arithmetically
  function automatic logic signed [11:0] phase_sext(input logic [11:0] ph,
                                                    input logic [2:0] code);
    logic signed [11:0] t;
    t = $signed(ph << (3'd7 - code));
    phase_sext = t >>> (3'd7 - code);
  endfunction

  // ---------------- system clock domain ----------------
  always_comb begin
    s_d = s_q;
    s_d.rst_s = {s_q.rst_s[0], reset_pin_n_i};
    s_d.avdd_s = {s_q.avdd_s[0], analog_supply_ok_i};
    s_d.dvdd_s = {s_q.dvdd_s[0], digital_supply_ok_i};
    if (s_q.avdd_s[1] && s_q.dvdd_s[1]) begin
      if (!s_q.por_done) begin
        if (s_q.por_cnt == POR_LAST) begin
          s_d.por_done = 1'b1;
        end else begin
          s_d.por_cnt = s_q.por_cnt + 1'b1;
        end
      end
    end else begin
      s_d.por_cnt = '0;
      s_d.por_done = 1'b0;
    end
    s_d.hold = !s_q.rst_s[1] || !s_q.por_done;
    if (s_q.hold) begin
      s_d.phase = PHASE_RST;
      s_d.oversampling_ratio = OSR_RST;
      s_d.ext_clk = EXT_CLK_RST;
      s_d.trim = TRIM_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        PHASE_HI_ADDR: begin
          s_d.phase[11:8] = reg_wdata_i[3:0];
          s_d.restart_t = !s_q.restart_t;
        end
        PHASE_LO_ADDR: begin
          s_d.phase[7:0] = reg_wdata_i;
          s_d.restart_t = !s_q.restart_t;
        end
        CONFIG_ADDR: begin
          s_d.oversampling_ratio = reg_wdata_i[CFG_OSR_LSB +: 3];
          s_d.ext_clk = reg_wdata_i[CFG_EXT_CLK_BIT];
        end
        TRIM_ADDR: s_d.trim = reg_wdata_i;
        default: ;
      endcase
    end
    unique case (reg_addr_i)
      PHASE_HI_ADDR: s_d.rdata = {4'h0, s_q.phase[11:8]};
      PHASE_LO_ADDR: s_d.rdata = s_q.phase[7:0];
      CONFIG_ADDR: s_d.rdata = {4'h0, s_q.ext_clk, s_q.oversampling_ratio};
      TRIM_ADDR: s_d.rdata = s_q.trim;
      default: s_d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.hold <= 1'b1;
      s_q.phase <= PHASE_RST;
      s_q.oversampling_ratio <= OSR_RST;
      s_q.ext_clk <= EXT_CLK_RST;
      s_q.trim <= TRIM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign reference_tempco_trim_o = s_q.trim;
  assign external_clock_select_o = s_q.ext_clk;

  // ---------------- digital master clock domain ----------------
  assign restart_ev = l_q.rst_t_s[2] ^ l_q.rst_t_s[1];
  assign len_m1 = 12'(osr_len(l_q.oversampling_ratio) - 13'd1);
  assign ph_eff = phase_sext(l_q.ph, l_q.oversampling_ratio);
  assign lag0 = (ph_eff > 0) ? ph_eff : 12'h000;
  assign lag1 = (ph_eff < 0) ? 12'(-ph_eff) : 12'h000;

  always_comb begin
    l_d = l_q;
    l_d.hold_s = {l_q.hold_s[0], s_q.hold};
    l_d.rst_t_s = {l_q.rst_t_s[1:0], s_q.restart_t};
    l_d.rdy_n = 1'b1;
    l_d.bias = 1'b1;
    // new phase lands in ph at the restart edge, lags use it one cycle later
    l_d.ld = restart_ev && !l_q.hold_s[1];
    if (l_q.hold_s[1]) begin
      // word is stable while held, so capture is safe
      l_d.ph = s_q.phase;
      l_d.oversampling_ratio = s_q.oversampling_ratio;
      l_d.dly = '0;
      l_d.win = '0;
      l_d.acc = '0;
      l_d.dat = '0;
      l_d.oe_n = 1'b1;
      l_d.mbit = 2'b00;
      l_d.cmp0 = CMP_RESET_CODE;
      l_d.cmp1 = CMP_RESET_CODE;
    end else if (restart_ev) begin
      l_d.ph = s_q.phase;
      l_d.oversampling_ratio = s_q.oversampling_ratio;
      l_d.dly = '0;
      l_d.win = '0;
      l_d.acc = '0;
      l_d.oe_n = 1'b0;
    end else begin
      l_d.oe_n = 1'b0;
      l_d.mbit = modulator_bit_i;
      l_d.cmp0 = cmp0_code_i;
      l_d.cmp1 = cmp1_code_i;
      // each channel counts its own modulator bit, and the window starts differ unless the phase is zero
      for (int i = 0; i < 2; i++) begin
        if (l_q.dly[i] != 12'h000) begin
          l_d.dly[i] = l_q.dly[i] - 12'h001;
        end else if (l_q.win[i] == len_m1) begin
          l_d.dat[i] = l_q.acc[i] + 13'(modulator_bit_i[i]);
          l_d.acc[i] = '0;
          l_d.win[i] = '0;
          l_d.rdy_n = 1'b0;
        end else begin
          l_d.acc[i] = l_q.acc[i] + 13'(modulator_bit_i[i]);
          l_d.win[i] = l_q.win[i] + 12'h001;
        end
      end
    end
    // delays load one cycle after a restart, not after a hold release
    if (l_q.hold_s[1] || restart_ev || l_q.ld) begin
      l_d.rdy_n = 1'b1;
    end
    if (l_q.ld && !l_q.hold_s[1] && !restart_ev) begin
      l_d.dly[0] = lag0;
      l_d.dly[1] = lag1;
      l_d.win = '0;
      l_d.acc = '0;
    end
  end

  always_ff @(posedge digital_master_clock_i) begin
    if (digital_master_clock_rst_i) begin
      l_q <= '0;
      l_q.hold_s <= 2'b11;
      l_q.rdy_n <= 1'b1;
      l_q.oe_n <= 1'b1;
      l_q.cmp0 <= CMP_RESET_CODE;
      l_q.cmp1 <= CMP_RESET_CODE;
      l_q.oversampling_ratio <= OSR_RST;
    end else begin
      l_q <= l_d;
    end
  end

  assign cmp0_code_o = l_q.cmp0;
  assign cmp1_code_o = l_q.cmp1;
  assign bias_enable_o = l_q.bias;
  assign ch0_data_o = l_q.dat[0];
  assign ch1_data_o = l_q.dat[1];
  assign sample_ready_n_o = l_q.rdy_n;
  assign sample_ready_n_oe_o = l_q.oe_n;
  assign modulator_bit_out_o = l_q.mbit;
  assign modulator_bit_out_oe_o = l_q.oe_n;

  // ---------------- checks ----------------
  sequence trim_wr_s;
    !s_q.hold && reg_wr_i && reg_addr_i == TRIM_ADDR;
  endsequence
  sequence held_wr_s;
    s_q.hold ##1 s_q.hold && reg_wr_i;
  endsequence

  chk_trim_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    trim_wr_s |=> reference_tempco_trim_o == $past(reg_wdata_i))
    else $error("trim write not stored");
  chk_trim_default: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_q.hold |=> reference_tempco_trim_o == TRIM_RST && s_q.phase == PHASE_RST)
    else $error("registers not at default in hold");
  chk_held_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    held_wr_s |=> $stable(s_q.trim) && $stable(s_q.phase) && $stable(s_q.restart_t))
    else $error("write taken during hold");
  chk_phase_hi_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    reg_addr_i == PHASE_HI_ADDR |=> reg_rdata_o[7:4] == 4'h0)
    else $error("phase high nibble not zero");
  chk_phase_restart: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !s_q.hold && reg_wr_i && (reg_addr_i == PHASE_HI_ADDR || reg_addr_i == PHASE_LO_ADDR)
    |=> s_q.restart_t != $past(s_q.restart_t))
    else $error("phase write gave no restart");
  chk_por_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_q.avdd_s[1] && s_q.dvdd_s[1] && !s_q.por_done && s_q.por_cnt == POR_LAST
    |=> s_q.por_done ##1 (s_q.hold == !$past(s_q.rst_s[1])))
    else $error("power-on release late");
  chk_ext_clock: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !s_q.hold && reg_wr_i && reg_addr_i == CONFIG_ADDR
    |=> external_clock_select_o == $past(reg_wdata_i[CFG_EXT_CLK_BIT]))
    else $error("clock select not stored");
  chk_hold_outputs: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    l_q.hold_s[1] |=> ch0_data_o == 13'h0 && ch1_data_o == 13'h0
      && sample_ready_n_oe_o && modulator_bit_out_oe_o)
    else $error("outputs not cleared in hold");
  chk_cmp_code: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    l_q.hold_s[1] |=> cmp0_code_o == CMP_RESET_CODE && cmp1_code_o == CMP_RESET_CODE
      && bias_enable_o)
    else $error("comparator code wrong in hold");
  chk_ready_pulse: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    !l_q.hold_s[1] && !restart_ev && !l_q.ld && l_q.dly[1] == 12'h0 && l_q.win[1] == len_m1
    |=> !sample_ready_n_o ##1 sample_ready_n_o || l_q.win[0] == 12'h0)
    else $error("ready pulse missing");
  chk_lag_load: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    l_q.ld && !l_q.hold_s[1] && !restart_ev
    |=> l_q.dly[0] == $past(lag0) && l_q.dly[1] == $past(lag1) && l_q.win == '0)
    else $error("phase delay not loaded");
  chk_ready_hold: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    l_q.hold_s[1] |=> sample_ready_n_o)
    else $error("ready pulsed in hold");
  chk_delay_count: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    !l_q.hold_s[1] && !restart_ev && !l_q.ld && l_q.dly[0] != 12'h0
    |=> l_q.dly[0] == $past(l_q.dly[0]) - 12'h001)
    else $error("delay counter not stepping");
  chk_lag_sign: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    l_q.ld && !l_q.hold_s[1] && !restart_ev && ph_eff > 0
    |=> l_q.dly[1] == 12'h000 && l_q.dly[0] != 12'h000)
    else $error("positive phase did not delay channel 0");
  chk_restart_clear: assert property (@(posedge digital_master_clock_i)
    disable iff (digital_master_clock_rst_i)
    restart_ev && !l_q.hold_s[1]
    |=> l_q.acc == '0 && l_q.win == '0 && sample_ready_n_o)
    else $error("restart did not clear windows");
endmodule

//--- test/apd_host.sv
// Purpose: host model on the register port and the ready line
// Assumes: the ready line has a pull-up at the host input
// Notes: the bench calls wr and rd; requests change 2 ns after an edge
`timescale 1ns/1ns
module apd_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic ready_n_i,
  input wire logic ready_oe_n_i,
  output logic ready_line_o
);
  // released line floats up
  assign ready_line_o = ready_oe_n_i ? 1'b1 : ready_n_i;
  initial begin
    wr_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 8'h00;
  end
  // trim is written only by the hard reset case
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #2;
    wr_o = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #2;
    addr_o = a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask
endmodule

//--- test/tb_apd_ctrl.sv
// Purpose: self-checking bench for the phase delay and reset control
// Assumes: short power-on count, ratio 32 in the timing cases
// Notes: ready pulses are judged against a queue of expected notes
`timescale 1ns/1ns
module tb_apd_ctrl;
  import apd_pkg::*;
  logic sys_clk_i = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic pin_n = 1'b1;
  logic a_ok = 1'b0;
  logic d_ok = 1'b0;
  logic [1:0] mbits = 2'b00;
  logic [3:0] c0 = 4'h5;
  logic [3:0] c1 = 4'ha;
  logic wr, rdy_n, rdy_oe, rdy_line, ext, bias, mb_oe;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, trim, rv, rb;
  logic [3:0] c0o, c1o;
  logic [12:0] d0, d1;
  logic [1:0] mbo;
  logic [9:0] q[$];
  logic [9:0] e;
  logic [7:0] lcnt = 8'h00;
  logic armed = 1'b0;
  // 0x1b is -5 with the sign at bit 4; 0x0f twice for a same-value rewrite
  logic [7:0] ph[4] = '{8'h00, 8'h1b, 8'h0f, 8'h0f};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'ha6a574de;
  int p;
  always #25 sys_clk_i = ~sys_clk_i;
  always #6 lclk = ~lclk;
  apd_ctrl #(.POR_CYCLES(8)) apd_ctrl_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(rst),
    .reset_pin_n_i(pin_n), .analog_supply_ok_i(a_ok), .digital_supply_ok_i(d_ok),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reference_tempco_trim_o(trim), .external_clock_select_o(ext),
    .digital_master_clock_i(lclk), .digital_master_clock_rst_i(rst), .modulator_bit_i(mbits),
    .cmp0_code_i(c0), .cmp1_code_i(c1), .cmp0_code_o(c0o), .cmp1_code_o(c1o),
    .bias_enable_o(bias), .ch0_data_o(d0), .ch1_data_o(d1), .sample_ready_n_o(rdy_n),
    .sample_ready_n_oe_o(rdy_oe), .modulator_bit_out_o(mbo),
    .modulator_bit_out_oe_o(mb_oe));
  apd_host apd_host_inst (.clk_i(sys_clk_i), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .ready_n_i(rdy_n), .ready_oe_n_i(rdy_oe), .ready_line_o(rdy_line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  // gap in link cycles since the last pulse, and which channels are full
  // sampled mid-cycle, away from the edge that launches the pulse
  always @(negedge lclk) begin
    lcnt <= lcnt + 8'd1;
    if (rdy_line === 1'b0) begin
      lcnt <= 8'd1;
      if (armed && q.size() > 0) begin
        e = q.pop_front();
        if (e[9:2] != 8'hff) check(lcnt, e[9:2]);
        check({d1 === 13'd32, d0 === 13'd32}, e[1:0]);
      end
    end
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    tick(8);
    rst = 1'b0;
    d_ok = 1'b1;
    tick(30);
    check(rdy_oe, 1'b1);
    a_ok = 1'b1;
    tick(30);
    check(rdy_oe, 1'b0);
    apd_host_inst.rd(TRIM_ADDR, rb);
    check(rb, 8'h42);
    apd_host_inst.rd(CONFIG_ADDR, rb);
    check(rb, 8'h03);
    apd_host_inst.rd(5'h1f, rb);
    check(rb, 8'h00);
    $display("startup test done");
    rv = 8'($random(seed));
    {c0, c1} = 8'($random(seed));
    mbits = 2'b10;
    apd_host_inst.wr(TRIM_ADDR, rv);
    apd_host_inst.rd(TRIM_ADDR, rb);
    check(rb, rv);
    apd_host_inst.wr(PHASE_HI_ADDR, 8'hff);
    apd_host_inst.rd(PHASE_HI_ADDR, rb);
    check(rb, 8'h0f);
    pin_n = 1'b0;
    tick(4);
    apd_host_inst.wr(TRIM_ADDR, 8'h55);
    tick(4);
    check(trim, 8'h42);
    check({rdy_oe, mb_oe, bias}, 3'b111);
    check({d0, d1}, 26'h0);
    check({c0o, c1o}, 8'h33);
    pin_n = 1'b1;
    tick(20);
    check({c0o, c1o, mbo, mb_oe}, {c0, c1, mbits, 1'b0});
    apd_host_inst.rd(PHASE_HI_ADDR, rb);
    check(rb, 8'h00);
    $display("hard reset test done");
    apd_host_inst.wr(CONFIG_ADDR, 8'h08);
    tick(2);
    check(ext, 1'b1);
    foreach (ph[i]) begin
      mbits = 2'b00;
      tick(80);
      p = int'($signed(ph[i][4:0]));
      q.push_back({8'hff, p > 0 ? 2'b10 : p < 0 ? 2'b01 : 2'b11});
      if (p != 0) q.push_back({8'(p < 0 ? -p : p), 2'b11});
      q.push_back({8'(p > 0 ? 32 - p : 32 + p), 2'b11});
      fork
        apd_host_inst.wr(PHASE_LO_ADDR, ph[i]);
        begin
          @(posedge sys_clk_i);
          #2;
          mbits = 2'b11;
        end
      join
      tick(2);
      // pulses before this point are discarded
      armed = 1'b1;
      for (int k = 0; k < 300 && q.size() > 0; k++) tick(1);
      armed = 1'b0;
      check(q.size(), 0);
      $display("phase test %0d done", i);
    end
    report_and_stop();
  end
endmodule
